//--- tfsc_period.sv
// Decoder from five-bit sync period code to period length in cycles
`timescale 1ns/1ps
`default_nettype none
module tfsc_period (
  // Code in
  input wire logic [4:0] code,
  // Decoded period
  output logic [31:0] period,
  output logic code_bad
);
  logic [5:0] expo;
  always_comb begin
    expo = 6'(code) + 6'(tfsc_pkg::PERIOD_OFFSET);
    code_bad = code > tfsc_pkg::CODE_MAX;
    // Saturate at 2^31: codes above the top value are unpredictable anyway
    if (code_bad) begin
      period = tfsc_pkg::PERIOD_SAT;
    end else begin
      period = tfsc_pkg::PERIOD_ONE << expo;
    end
  end
endmodule : tfsc_period
`default_nettype wire

//--- tfsc_pkg.sv
// Package: field layout, reset values and timing constants of the trace filter/sync control register
package tfsc_pkg;
  localparam int REG_W = 32;
  localparam int SPX_HI = 31;
  localparam int SPX_LO = 30;
  localparam int CSV_BIT = 29;
  localparam int CSN_HI = 28;
  localparam int CSN_LO = 21;
  localparam int TSV_BIT = 20;
  localparam int TSN_HI = 19;
  localparam int TSN_LO = 12;
  localparam int LOW_HI = 11;
  localparam int SPC_HI = 2;
  localparam int SPC_LO = 0;
  localparam int CODE_W = 5;
  localparam int PERIOD_OFFSET = 5;
  localparam logic [4:0] CODE_MAX = 5'h1A;
  localparam logic [7:0] EXT_REV_MIN = 8'h06;
  localparam logic [1:0] SPX_RESET = 2'h0;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [4:0] REG_NUM = 5'h17;
  localparam logic [2:0] REG_SEL = 3'h2;
  localparam logic [2:0] PERIOD_CODE_LO_RESET = 3'h0;
  localparam logic [31:0] PERIOD_ONE = 32'h0000_0001;
  localparam logic [31:0] PERIOD_SAT = 32'h8000_0000;
endpackage : tfsc_pkg

//--- tfsc_reg.sv
// Trace filter and sync control register: upper fields, filters and sync period
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Extension bits are code's upper two bits
// - Sync period is two to code plus five
// - Extension resets zero, writable from revision six
// - Core-select valid limits tracing to one core
// - Thread filter overrides core filter when multithreaded
// - Core number names element or core
// - Core select reads zero without support
// - Thread-select valid limits tracing to one thread
// - Only needed low thread-number bits are used
// - Thread select reads zero without multithreading
// - Read-only fields come from control block
module tfsc_reg #(
  parameter bit HAS_MT = 1'b1,
  parameter bit HAS_MULTICORE = 1'b0,
  parameter int TC_BITS = 3,
  parameter logic [7:0] TRACE_REV = 8'h06
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Coprocessor register access
  input wire logic [4:0] REG_ADDR,
  input wire logic [2:0] REG_SELECT,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // Read-only low bits supplied by the control block
  input wire logic [11:0] CTRL_BLOCK_LOW,
  // Current executing element, core and thread context
  input wire logic [7:0] CUR_CORE_NUM,
  input wire logic [7:0] CUR_THREAD_NUM,
  // Filter result and sync period
  output logic TRACE_SELECT_OK,
  output logic [31:0] SYNC_PERIOD,
  output logic SYNC_CODE_BAD
);
  localparam bit CORE_IMPL = HAS_MT | HAS_MULTICORE;
  localparam bit EXT_IMPL = TRACE_REV >= tfsc_pkg::EXT_REV_MIN;

  typedef struct packed {
    logic [1:0] spx;
    logic csv;
    logic [7:0] csn;
    logic tsv;
    logic [7:0] tsn;
    logic [11:0] low;
    logic [31:0] rdata;
    logic sel_ok;
  } tfsc_state_t;

  tfsc_state_t s_q;
  tfsc_state_t s_d;
  logic hit;
  logic [4:0] code;
  logic [7:0] tc_mask;
  logic core_match;
  logic thread_match;

  assign hit = REG_WR && REG_ADDR == tfsc_pkg::REG_NUM && REG_SELECT == tfsc_pkg::REG_SEL;
  assign code = {s_q.spx, s_q.low[tfsc_pkg::SPC_HI:tfsc_pkg::SPC_LO]};
  assign tc_mask = 8'((9'h001 << TC_BITS) - 9'h001);

  always_comb begin
    s_d = s_q;
    // Low bits are mirrored from the control block every cycle
    s_d.low = CTRL_BLOCK_LOW;
    if (hit) begin
      if (EXT_IMPL) begin
        s_d.spx = REG_WDATA[tfsc_pkg::SPX_HI:tfsc_pkg::SPX_LO];
      end
      if (CORE_IMPL) begin
        s_d.csv = REG_WDATA[tfsc_pkg::CSV_BIT];
        s_d.csn = REG_WDATA[tfsc_pkg::CSN_HI:tfsc_pkg::CSN_LO];
      end
      if (HAS_MT) begin
        s_d.tsv = REG_WDATA[tfsc_pkg::TSV_BIT];
        s_d.tsn = REG_WDATA[tfsc_pkg::TSN_HI:tfsc_pkg::TSN_LO];
      end
    end
    // Unimplemented fields stay zero whatever is written
    if (!EXT_IMPL) s_d.spx = tfsc_pkg::SPX_RESET;
    if (!CORE_IMPL) begin
      s_d.csv = 1'b0;
      s_d.csn = tfsc_pkg::SEL_RESET;
    end
    if (!HAS_MT) begin
      s_d.tsv = 1'b0;
      s_d.tsn = tfsc_pkg::SEL_RESET;
    end
    s_d.rdata = {s_d.spx, s_d.csv, s_d.csn, s_d.tsv, s_d.tsn, s_d.low};
    core_match = CUR_CORE_NUM == s_d.csn;
    thread_match = (CUR_THREAD_NUM & tc_mask) == (s_d.tsn & tc_mask);
    if (HAS_MT && s_d.tsv) begin
      s_d.sel_ok = thread_match;
    end else if (s_d.csv) begin
      s_d.sel_ok = core_match;
    end else begin
      s_d.sel_ok = 1'b1;
    end
  end

  // Select fields have no architected reset when implemented; zero is a safe choice
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.sel_ok <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA = s_q.rdata;
  assign TRACE_SELECT_OK = s_q.sel_ok;

  tfsc_period u_period (
    .code(code),
    .period(SYNC_PERIOD),
    .code_bad(SYNC_CODE_BAD)
  );
endmodule : tfsc_reg
`default_nettype wire

//--- tfsc_reg_checker.sv
// Checker: register image, sync period and filter result
`timescale 1ns/1ps
`default_nettype none
module tfsc_reg_checker (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Watched ports
  input wire logic REG_WR,
  input wire logic [31:0] REG_RDATA,
  input wire logic [11:0] CTRL_BLOCK_LOW,
  input wire logic [7:0] CUR_CORE_NUM,
  input wire logic [7:0] CUR_THREAD_NUM,
  input wire logic TRACE_SELECT_OK,
  input wire logic [31:0] SYNC_PERIOD,
  input wire logic SYNC_CODE_BAD
);
  logic [4:0] code;
  assign code = {REG_RDATA[31:30], REG_RDATA[2:0]};
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  period_decode_a: assert property (!SYNC_CODE_BAD |-> SYNC_PERIOD == 32'h0000_0001 << (code + 5'h05))
    else $error("period decode");
  code_limit_a: assert property (SYNC_CODE_BAD == (code > 5'h1A))
    else $error("code flag");
  period_sat_a: assert property (SYNC_CODE_BAD |-> SYNC_PERIOD == 32'h8000_0000)
    else $error("period saturate");
  low_bits_a: assert property ($past(RST_N) |-> REG_RDATA[11:0] == $past(CTRL_BLOCK_LOW))
    else $error("low bits");
  upper_hold_a: assert property (!$past(REG_WR) && $past(RST_N) |-> $stable(REG_RDATA[31:12]))
    else $error("upper hold");
  thread_filter_a: assert property (REG_RDATA[20] && $past(RST_N)
    |-> TRACE_SELECT_OK == ($past(CUR_THREAD_NUM[2:0]) == REG_RDATA[14:12]))
    else $error("thread filter");
  core_filter_a: assert property (!REG_RDATA[20] && REG_RDATA[29] && $past(RST_N)
    |-> TRACE_SELECT_OK == ($past(CUR_CORE_NUM) == REG_RDATA[28:21]))
    else $error("core filter");
  open_filter_a: assert property (!REG_RDATA[20] && !REG_RDATA[29] |-> TRACE_SELECT_OK)
    else $error("open filter");
endmodule : tfsc_reg_checker
bind tfsc_reg tfsc_reg_checker tfsc_reg_checker_i (.*);
`default_nettype wire

//--- tfsc_reg_tb_top.sv
// Testbench: table of register writes, then unmapped and reset cases
`timescale 1ns/1ps
`default_nettype none
module tfsc_reg_tb_top;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, ok, bad;
  logic [4:0] addr = 5'h17;
  logic [2:0] sel = 3'h2;
  logic [7:0] cur_core = 8'h05, cur_thr = 8'h0B;
  logic [4:0] code;
  logic [31:0] wd = 32'h0000_0000, rd, per;
  logic [11:0] low = 12'h000;
  int mismatches = 0, n_tests = 0, cyc = 0;
  logic [31:0] t_wd [7] = '{32'h0000_0000, 32'h60A0_0000, 32'h20C0_0000, 32'h20DF_3000, 32'h0010_4000,
    32'hC000_0000, 32'hC000_0000};
  logic [2:0] t_sc [7] = '{3'h0, 3'h1, 3'h7, 3'h4, 3'h5, 3'h2, 3'h3};
  logic t_ok [7] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
  tfsc_reg tfsc_reg_i (.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_SELECT(sel), .REG_WR(wr),
    .REG_WDATA(wd), .REG_RDATA(rd), .CTRL_BLOCK_LOW(low), .CUR_CORE_NUM(cur_core), .CUR_THREAD_NUM(cur_thr),
    .TRACE_SELECT_OK(ok), .SYNC_PERIOD(per), .SYNC_CODE_BAD(bad));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial forever #50 clk = ~clk;
  // Whole run is about 30 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 200) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    chk("reset image", 32'h0000_0000, rd);
    chk("reset period", 32'h0000_0020, per);
    rst_n = 1'h1;
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      wd = t_wd[i];
      low = {9'h000, t_sc[i]};
      wr = 1'h1;
      @(negedge clk);
      wr = 1'h0;
      code = {t_wd[i][31:30], t_sc[i]};
      chk("filter", {31'h0000_0000, t_ok[i]}, {31'h0000_0000, ok});
      chk("period", code > 5'h1A ? 32'h8000_0000 : 32'h0000_0001 << (code + 5'h05), per);
      chk("code flag", {31'h0000_0000, code > 5'h1A}, {31'h0000_0000, bad});
    end
    // Thread filter must follow a change of the running thread without a new write
    @(negedge clk);
    wd = 32'h0010_3000;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
    chk("thread hit", 32'h0000_0001, {31'h0000_0000, ok});
    cur_thr = 8'h0C;
    @(negedge clk);
    chk("thread miss", 32'h0000_0000, {31'h0000_0000, ok});
    addr = 5'h16;
    wd = 32'hFFFF_F000;
    wr = 1'h1;
    @(negedge clk);
    addr = 5'h17;
    sel = 3'h3;
    @(negedge clk);
    wr = 1'h0;
    chk("unmapped", 32'h0000_0103, {12'h000, rd[31:12]});
    rst_n = 1'h0;
    low = 12'h001;
    @(negedge clk);
    chk("reset", 32'h0000_0000, {rd[31:12], 12'h000});
    chk("reset filter", 32'h0000_0001, {31'h0000_0000, ok});
    chk("reset flag", 32'h0000_0000, {31'h0000_0000, bad});
    // First write is taken at the first edge after release
    rst_n = 1'h1;
    sel = 3'h2;
    wd = 32'h4000_0000;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
    chk("after reset", 32'h0004_0000, {12'h000, rd[31:12]});
    chk("period after reset", 32'h0000_4000, per);
    final_report();
  end
endmodule : tfsc_reg_tb_top
`default_nettype wire
